// >>> sac_pkg.sv
// Package for the successive approximation converter control: map, fields, timing, types
package sac_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register word indices; byte address is four times the index
	localparam logic [9:0]  SAC_IDX_CTRL0     = 10'h010;
	localparam logic [9:0]  SAC_IDX_STAT      = 10'h011;
	localparam logic [9:0]  SAC_IDX_RES0      = 10'h020;
	localparam logic [9:0]  SAC_IDX_CTRL1     = 10'h397;
	localparam int unsigned SAC_NUM_CH        = 10;
	localparam logic [9:0]  SAC_NUM_CH_W      = 10'h00a;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int unsigned SAC_C0_START_BIT  = 7;
	localparam int unsigned SAC_C0_TRIG_BIT   = 6;
	localparam int unsigned SAC_C1_REF_BIT    = 5;
	localparam int unsigned SAC_C0_W          = 10;
	localparam int unsigned SAC_C1_W          = 8;
	localparam logic [9:0]  SAC_C0_RESET      = 10'h000;
	localparam logic [7:0]  SAC_C1_RESET      = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion timing in conversion-clock cycles
	localparam int unsigned SAC_TICKS_PER_BIT = 2;
	localparam int unsigned SAC_CYC_NOSH_8    = 49;
	localparam int unsigned SAC_CYC_NOSH_10   = 59;
	localparam int unsigned SAC_CYC_SH_8      = 28;
	localparam int unsigned SAC_CYC_SH_10     = 33;
	localparam logic [6:0]  SAC_SMP_NOSH_8    = 7'(SAC_CYC_NOSH_8 - SAC_TICKS_PER_BIT * 8);
	localparam logic [6:0]  SAC_SMP_NOSH_10   = 7'(SAC_CYC_NOSH_10 - SAC_TICKS_PER_BIT * 10);
	localparam logic [6:0]  SAC_SMP_SH_8      = 7'(SAC_CYC_SH_8 - SAC_TICKS_PER_BIT * 8);
	localparam logic [6:0]  SAC_SMP_SH_10     = 7'(SAC_CYC_SH_10 - SAC_TICKS_PER_BIT * 10);
	localparam logic [3:0]  SAC_MSB           = 4'h9;
	localparam logic [3:0]  SAC_LSB_10        = 4'h0;
	localparam logic [3:0]  SAC_LSB_8         = 4'h2;
	localparam logic [9:0]  SAC_CODE_MID      = 10'h200;

	////////////////////////////////////////////////////////////////////////////////
	// Enumerations
	typedef enum logic [2:0] {
		SAC_MODE_ONESHOT = 3'h0,
		SAC_MODE_REPEAT  = 3'h1,
		SAC_MODE_SWEEP   = 3'h2,
		SAC_MODE_RSWEEP0 = 3'h3,
		SAC_MODE_RSWEEP1 = 3'h4
	} sac_mode_t;

	typedef enum logic [1:0] {
		SAC_DIV_1 = 2'h0,
		SAC_DIV_2 = 2'h1,
		SAC_DIV_4 = 2'h2
	} sac_div_t;

	typedef enum logic [1:0] {
		SAC_ST_IDLE = 2'b00,
		SAC_ST_CONV = 2'b01
	} sac_state_t;

	typedef enum logic [1:0] {
		SAC_SEQ_IDLE   = 2'b00,
		SAC_SEQ_SAMPLE = 2'b01,
		SAC_SEQ_BITS   = 2'b11
	} sac_seq_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Register layouts and analog front-end bundle
	typedef struct packed {
		logic       ext_idx;
		logic       ext_sel;
		logic       start;
		logic       trig_ext;
		logic [2:0] mode;
		logic [2:0] chan;
	} sac_ctrl0_t;

	typedef struct packed {
		logic [1:0] div;
		logic       ref_connect;
		logic       rsvd;
		logic       sh_en;
		logic       res10;
		logic [1:0] grp;
	} sac_ctrl1_t;

	typedef struct packed {
		logic       sampling;
		logic       busy;
		logic [3:0] cur_ch;
	} sac_stat_t;

	typedef struct packed {
		logic       ref_connect;
		logic [3:0] mux_sel;
		logic       sample;
		logic [9:0] dac_code;
	} sac_afe_t;

endpackage : sac_pkg

// >>> sac_sar_seq.sv
// Successive approximation sequencer: sample phase then one decision per bit
`timescale 1ns/10ps
module sac_sar_seq
	import sac_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Control
	input  wire logic       i_tick,
	input  wire logic       i_start,
	input  wire logic       i_abort,
	input  wire logic       i_res10,
	input  wire logic       i_sh_en,
	input  wire logic       i_cmp_high,
	// Status and result
	output logic [9:0]      o_code,
	output logic            o_sample,
	output logic            o_busy,
	output logic            o_done,
	output logic [9:0]      o_result
);

	sac_seq_state_t state_r, state_nxt;
	logic [6:0]     cnt_r, cnt_nxt;
	logic [3:0]     bit_r, bit_nxt;
	logic           half_r, half_nxt;
	logic [9:0]     code_r, code_nxt;
	logic [9:0]     result_r, result_nxt;
	logic           done_r, done_nxt;
	logic [9:0]     decided;
	logic [6:0]     smp_len;
	logic [3:0]     lsb;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		case ({i_sh_en, i_res10})
			2'b00:   smp_len = SAC_SMP_NOSH_8;
			2'b01:   smp_len = SAC_SMP_NOSH_10;
			2'b10:   smp_len = SAC_SMP_SH_8;
			default: smp_len = SAC_SMP_SH_10;
		endcase
		lsb        = i_res10 ? SAC_LSB_10 : SAC_LSB_8;
		decided    = code_r;
		if (!i_cmp_high)
			decided[bit_r] = 1'b0;
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		bit_nxt    = bit_r;
		half_nxt   = half_r;
		code_nxt   = code_r;
		result_nxt = result_r;
		done_nxt   = 1'b0;
		case (state_r)
			SAC_SEQ_IDLE: ;
			SAC_SEQ_SAMPLE:
				if (i_tick)
				begin
					if (cnt_r == 7'h00)
					begin
						state_nxt = SAC_SEQ_BITS;
						bit_nxt   = SAC_MSB;
						code_nxt  = SAC_CODE_MID;
						half_nxt  = 1'b0;
					end
					else
						cnt_nxt = cnt_r - 7'h01;
				end
			SAC_SEQ_BITS:
				if (i_tick)
				begin
					// First tick settles the ladder, second one decides
					half_nxt = ~half_r;
					if (half_r)
					begin
						code_nxt = decided;
						if (bit_r == lsb)
						begin
							state_nxt  = SAC_SEQ_IDLE;
							done_nxt   = 1'b1;
							result_nxt = i_res10 ? decided : {2'h0, decided[9:2]};
						end
						else
						begin
							bit_nxt  = bit_r - 4'h1;
							code_nxt = decided | (10'h001 << (bit_r - 4'h1));
						end
					end
				end
			default: state_nxt = SAC_SEQ_IDLE;
		endcase
		if (i_start)
		begin
			state_nxt = SAC_SEQ_SAMPLE;
			cnt_nxt   = smp_len - 7'h01;
			code_nxt  = 10'h000;
			half_nxt  = 1'b0;
		end
		else if (i_abort)
			state_nxt = SAC_SEQ_IDLE;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r  <= SAC_SEQ_IDLE;
			cnt_r    <= 7'h00;
			bit_r    <= 4'h0;
			half_r   <= 1'b0;
			code_r   <= 10'h000;
			result_r <= 10'h000;
			done_r   <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			bit_r    <= bit_nxt;
			half_r   <= half_nxt;
			code_r   <= code_nxt;
			result_r <= result_nxt;
			done_r   <= done_nxt;
		end
	end

	assign o_code   = code_r;
	assign o_sample = (state_r == SAC_SEQ_SAMPLE);
	assign o_busy   = (state_r != SAC_SEQ_IDLE);
	assign o_done   = done_r;
	assign o_result = result_r;

endmodule : sac_sar_seq

// >>> sac_top.sv
// Converter control top: APB registers, triggering, modes, clock divider, result store
//
// Functional notes
// - One shared 10-bit successive approximation engine serves every input channel.
// - Clearing the reference-connect bit detaches the ladder from the reference.
// - Each result lands in the result register of the channel converted.
// - 10-bit results: low eight bits in even byte, top two in odd byte.
// - 8-bit results: all eight bits in the even byte.
// - Modes: one-shot, repeat, single sweep, repeat sweep 0, repeat sweep 1.
// - Multiplexer addresses eight primary inputs plus two extension inputs.
// - Software trigger: start flag going zero to one starts conversion.
// - External trigger: falling trigger edge starts conversion while start flag set.
// - A further falling trigger edge restarts conversion.
// - Without sample-and-hold: 49 cycles at 8-bit, 59 at 10-bit.
// - With sample-and-hold: 28 cycles at 8-bit, 33 at 10-bit.
// - Conversion clock is system clock undivided, halved or quartered.
// - One-shot: convert once, clear start unless external, request interrupt.
// - Repeat: convert continuously until start cleared, no interrupt.
// - Sweeps cover first two, four, six or eight primary channels in turn.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module sac_top
	import sac_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	// APB slave
	input  wire logic [11:0] i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Trigger pin and comparator
	input  wire logic        i_ext_conv_trigger_in,
	input  wire logic        i_cmp_high,
	// Analog front end and completion request
	output sac_afe_t         o_afe,
	output logic             o_conv_irq_req
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_r;
	logic       rst_n;
	logic [1:0] trig_sync_r;
	logic       trig_prev_r;
	logic       trig_fall;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Trigger idles high so a reset does not fake a falling edge
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_sync_r <= 2'b11;
			trig_prev_r <= 1'b1;
		end
		else
		begin
			trig_sync_r <= {trig_sync_r[0], i_ext_conv_trigger_in};
			trig_prev_r <= trig_sync_r[1];
		end
	end
	assign trig_fall = trig_prev_r & ~trig_sync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// Conversion clock enable
	sac_ctrl1_t ctrl1_r, ctrl1_nxt;
	logic [1:0] div_cnt_r, div_cnt_nxt;
	logic       conv_clock;
	logic       seq_start;

	always_comb
	begin
		// Restart the divider per channel so a conversion spans whole periods
		div_cnt_nxt = seq_start ? 2'h0 : div_cnt_r + 2'h1;
		case (ctrl1_r.div)
			SAC_DIV_1: conv_clock = 1'b1;
			SAC_DIV_2: conv_clock = div_cnt_r[0];
			default:   conv_clock = (div_cnt_r == 2'h3);
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt_r <= 2'h0;
		else
			div_cnt_r <= div_cnt_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	logic       seq_abort;
	logic       seq_done;
	logic       seq_busy;
	logic       seq_sample;
	logic [9:0] seq_code;
	logic [9:0] seq_result;

	// Comparator is latched on this clock; two sync stages would miss the bit slot
	sac_sar_seq u_seq (
		.i_clk      (i_clk_sys),
		.i_rst_n    (rst_n),
		.i_tick     (conv_clock),
		.i_start    (seq_start),
		.i_abort    (seq_abort),
		.i_res10    (ctrl1_r.res10),
		.i_sh_en    (ctrl1_r.sh_en),
		.i_cmp_high (i_cmp_high),
		.o_code     (seq_code),
		.o_sample   (seq_sample),
		.o_busy     (seq_busy),
		.o_done     (seq_done),
		.o_result   (seq_result)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Control, mode sequencing and registers
	sac_state_t state_r, state_nxt;
	sac_ctrl0_t ctrl0_r, ctrl0_nxt;
	logic [3:0] cur_ch_r, cur_ch_nxt;
	logic [2:0] pos_r, pos_nxt;
	logic       irq_r, irq_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [9:0] res_r [SAC_NUM_CH];
	logic [9:0] idx;
	logic [9:0] ridx;
	logic       wr_acc;
	logic       mapped;
	logic       go_sw;
	logic       go_ext;
	logic       finish;
	logic [2:0] last_ch;
	logic [3:0] first_ch;
	sac_ctrl0_t wr_c0;
	sac_stat_t  stat;

	assign idx    = i_paddr[11:2];
	assign ridx   = idx - SAC_IDX_RES0;
	assign wr_acc = i_psel & i_penable & i_pwrite;
	assign wr_c0  = i_pwdata[SAC_C0_W-1:0];
	assign stat   = '{sampling: seq_sample, busy: (state_r == SAC_ST_CONV), cur_ch: cur_ch_r};

	always_comb
	begin
		state_nxt  = state_r;
		ctrl0_nxt  = ctrl0_r;
		ctrl1_nxt  = ctrl1_r;
		cur_ch_nxt = cur_ch_r;
		pos_nxt    = pos_r;
		irq_nxt    = 1'b0;
		prdata_nxt = prdata_r;
		seq_start  = 1'b0;
		seq_abort  = 1'b0;
		finish     = 1'b0;
		last_ch    = {ctrl1_r.grp, 1'b1};
		// Extension inputs only make sense for single-channel modes
		if ((ctrl0_r.mode == SAC_MODE_ONESHOT) || (ctrl0_r.mode == SAC_MODE_REPEAT))
			first_ch = ctrl0_r.ext_sel ? {3'b100, ctrl0_r.ext_idx}
			                           : {1'b0, ctrl0_r.chan};
		else
			first_ch = 4'h0;

		// End of one channel: store happens in the result bank
		if ((state_r == SAC_ST_CONV) && seq_done)
		begin
			case (ctrl0_r.mode)
				SAC_MODE_ONESHOT: finish = 1'b1;
				SAC_MODE_REPEAT:  seq_start = 1'b1;
				SAC_MODE_SWEEP, SAC_MODE_RSWEEP0:
				begin
					if (cur_ch_r[2:0] == last_ch)
					begin
						if (ctrl0_r.mode == SAC_MODE_SWEEP)
							finish = 1'b1;
						else
						begin
							cur_ch_nxt = 4'h0;
							seq_start  = 1'b1;
						end
					end
					else
					begin
						cur_ch_nxt = cur_ch_r + 4'h1;
						seq_start  = 1'b1;
					end
				end
				SAC_MODE_RSWEEP1:
				begin
					// Channel 0 is interleaved between every other group member
					if (cur_ch_r == 4'h0)
						cur_ch_nxt = {1'b0, pos_r};
					else
					begin
						pos_nxt    = (pos_r == last_ch) ? 3'h1 : pos_r + 3'h1;
						cur_ch_nxt = 4'h0;
					end
					seq_start = 1'b1;
				end
				default: finish = 1'b1;
			endcase
			if (finish)
			begin
				state_nxt = SAC_ST_IDLE;
				irq_nxt   = 1'b1;
				if (!ctrl0_r.trig_ext)
					ctrl0_nxt.start = 1'b0;
			end
		end

		// Start flag cleared by software stops any mode
		if ((state_r == SAC_ST_CONV) && !ctrl0_r.start)
		begin
			state_nxt = SAC_ST_IDLE;
			seq_start = 1'b0;
			seq_abort = 1'b1;
		end

		go_sw  = wr_acc && (idx == SAC_IDX_CTRL0) && wr_c0.start && !ctrl0_r.start
		         && !wr_c0.trig_ext;
		go_ext = trig_fall && ctrl0_r.start && ctrl0_r.trig_ext;
		if (go_sw || go_ext)
		begin
			state_nxt  = SAC_ST_CONV;
			seq_start  = 1'b1;
			seq_abort  = 1'b0;
			pos_nxt    = 3'h1;
			if (go_sw)
				cur_ch_nxt = (wr_c0.mode <= SAC_MODE_REPEAT)
				             ? (wr_c0.ext_sel ? {3'b100, wr_c0.ext_idx} : {1'b0, wr_c0.chan})
				             : 4'h0;
			else
				cur_ch_nxt = first_ch;
		end

		// Software write last, so a set of the start flag beats a hardware clear
		if (wr_acc && (idx == SAC_IDX_CTRL0))
			ctrl0_nxt = wr_c0;
		if (wr_acc && (idx == SAC_IDX_CTRL1))
		begin
			ctrl1_nxt      = i_pwdata[SAC_C1_W-1:0];
			ctrl1_nxt.rsvd = 1'b0;
		end

		// Read data captured in the setup phase
		mapped = 1'b1;
		case (idx)
			SAC_IDX_CTRL0: prdata_nxt = {22'h0, ctrl0_r};
			SAC_IDX_CTRL1: prdata_nxt = {24'h0, ctrl1_r};
			SAC_IDX_STAT:  prdata_nxt = {26'h0, stat};
			default:
				if (ridx < SAC_NUM_CH_W)
					prdata_nxt = {22'h0, res_r[ridx[3:0]]};
				else
				begin
					prdata_nxt = 32'h0000_0000;
					mapped     = 1'b0;
				end
		endcase
		if (!(i_psel && !i_penable && !i_pwrite))
			prdata_nxt = prdata_r;
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r  <= SAC_ST_IDLE;
			ctrl0_r  <= SAC_C0_RESET;
			ctrl1_r  <= SAC_C1_RESET;
			cur_ch_r <= 4'h0;
			pos_r    <= 3'h1;
			irq_r    <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			state_r  <= state_nxt;
			ctrl0_r  <= ctrl0_nxt;
			ctrl1_r  <= ctrl1_nxt;
			cur_ch_r <= cur_ch_nxt;
			pos_r    <= pos_nxt;
			irq_r    <= irq_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result bank, one word per channel
	genvar g;
	generate
		for (g = 0; g < SAC_NUM_CH; g++)
		begin : g_res
			logic [9:0] res_nxt;
			assign res_nxt = (seq_done && (state_r == SAC_ST_CONV) && (cur_ch_r == 4'(g)))
			                 ? seq_result : res_r[g];
			always_ff @(posedge i_clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					res_r[g] <= 10'h000;
				else
					res_r[g] <= res_nxt;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_prdata         = prdata_r;
	assign o_pready         = 1'b1;
	assign o_pslverr        = i_psel & i_penable & ~mapped;
	assign o_conv_irq_req   = irq_r;
	assign o_afe = '{ref_connect: ctrl1_r.ref_connect,
	                 mux_sel:     cur_ch_r,
	                 sample:      seq_sample,
	                 dac_code:    seq_code};

endmodule : sac_top

// >>> sac_top_properties.sv
// Port-level assertion checker for the converter control top
`timescale 1ns/10ps
module sac_top_properties
	import sac_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_reset_n,
	input wire logic [11:0] i_paddr,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_ext_conv_trigger_in,
	input wire logic        i_cmp_high,
	input wire sac_afe_t    o_afe,
	input wire logic        o_conv_irq_req
);
	logic [9:0] idx;
	logic       mapped;
	sac_ctrl0_t c0_r;
	sac_ctrl0_t c0_nxt;
	sac_ctrl1_t c1_r;
	sac_ctrl1_t c1_nxt;

	assign idx = i_paddr[11:2];
	assign mapped = idx == SAC_IDX_CTRL0 || idx == SAC_IDX_STAT || idx == SAC_IDX_CTRL1
		|| (idx >= SAC_IDX_RES0 && idx < SAC_IDX_RES0 + SAC_NUM_CH_W);

	////////////////////////////////////////////////////////////////////////////////
	// Shadow of software writes; hardware clearing of start is not tracked
	always_comb
	begin
		c0_nxt = c0_r;
		c1_nxt = c1_r;
		if (i_psel && i_penable && i_pwrite && idx == SAC_IDX_CTRL0)
			c0_nxt = i_pwdata[9:0];
		if (i_psel && i_penable && i_pwrite && idx == SAC_IDX_CTRL1)
		begin
			c1_nxt = i_pwdata[7:0];
			c1_nxt.rsvd = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			c0_r <= '0;
			c1_r <= '0;
		end
		else
		begin
			c0_r <= c0_nxt;
			c1_r <= c1_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	sequence acc_s;
		i_psel && i_penable;
	endsequence
	sequence wr1_s;
		acc_s ##0 (i_pwrite && idx == SAC_IDX_CTRL1);
	endsequence
	sequence rd1_s;
		acc_s ##0 (!i_pwrite && idx == SAC_IDX_CTRL1);
	endsequence

	apb_ready_a: assert property (acc_s |-> o_pready)
		else $error("pready low in access phase");
	apb_slverr_a: assert property (acc_s |-> o_pslverr == !mapped)
		else $error("pslverr does not match address map");
	ref_follow_a: assert property (wr1_s |=> o_afe.ref_connect == c1_r.ref_connect)
		else $error("ladder connect does not follow control bit");
	ctrl1_read_a: assert property (rd1_s |-> o_prdata == {24'h0, c1_r})
		else $error("control 1 read back wrong");
	mux_range_a: assert property (o_afe.sample |-> o_afe.mux_sel <= 4'h9)
		else $error("multiplexer select out of range");
	irq_pulse_a: assert property ($rose(o_conv_irq_req) |=> !o_conv_irq_req)
		else $error("completion request longer than one cycle");
	irq_mode_a: assert property (o_conv_irq_req |-> c0_r.mode inside {SAC_MODE_ONESHOT, SAC_MODE_SWEEP})
		else $error("completion request in a repeating mode");
	sweep_range_a: assert property (o_afe.sample && c0_r.mode inside {SAC_MODE_SWEEP,
		SAC_MODE_RSWEEP0, SAC_MODE_RSWEEP1} |-> o_afe.mux_sel <= {1'b0, c1_r.grp, 1'b1})
		else $error("sweep channel outside group");
	chan_sel_a: assert property (o_afe.sample && !c0_r.ext_sel && c0_r.mode inside
		{SAC_MODE_ONESHOT, SAC_MODE_REPEAT} |-> o_afe.mux_sel == {1'b0, c0_r.chan})
		else $error("converted channel differs from selection");
endmodule : sac_top_properties

bind sac_top sac_top_properties u_props (
	.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_paddr(i_paddr), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_conv_trigger_in(i_ext_conv_trigger_in),
	.i_cmp_high(i_cmp_high), .o_afe(o_afe), .o_conv_irq_req(o_conv_irq_req)
);

// >>> sac_afe_model.sv
// Behavioural comparator, ladder and input multiplexer
`timescale 1ns/10ps
module sac_afe_model
	import sac_pkg::*;
(
	input  wire logic        i_clk,
	input  wire sac_afe_t    i_afe,
	input  wire logic [99:0] i_levels,
	output logic             o_cmp_high
);
	logic [9:0] level;
	logic       wobble_r = 1'b0;

	// One comparator shared by every input; analog inputs are only read, never driven
	assign level = i_levels[10 * int'(i_afe.mux_sel) +: 10];
	// Latched comparator; detached ladder or bad select gives no valid decision
	always_ff @(posedge i_clk)
	begin
		wobble_r   <= !wobble_r;
		o_cmp_high <= (i_afe.ref_connect && i_afe.mux_sel <= 4'h9) ?
			(level >= i_afe.dac_code) : wobble_r;
	end
endmodule : sac_afe_model

// >>> sac_top_tb.sv
// Self-checking bench for the converter control top
`timescale 1ns/10ps
module sac_top_tb
	import sac_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        trig;
	logic        cmp;
	sac_afe_t    afe;
	logic        irq;
	logic [99:0] levels;
	logic [31:0] rd;
	logic        rd_err;
	logic [2:0]  ch;
	logic [2:0]  md;
	int          seed = 13285;
	int          err_count = 0;
	int          checked = 0;
	int          irq_n = 0;
	int          cyc;
	int          n;
	int          d;

	sac_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_paddr(paddr), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_ext_conv_trigger_in(trig),
		.i_cmp_high(cmp), .o_afe(afe), .o_conv_irq_req(irq));
	sac_afe_model afe_m (.i_clk(clk), .i_afe(afe), .i_levels(levels), .o_cmp_high(cmp));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk)
		if (irq === 1'b1)
			irq_n++;

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		check("pready", 1, pready);
		if (pready !== 1'b1)
			close_out();
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_irq(input int lim);
		cyc = 0;
		while (irq !== 1'b1 && cyc < lim)
		begin
			@(posedge clk);
			#1;
			cyc++;
		end
		check("completion request", 1, irq);
		if (irq !== 1'b1)
			close_out();
	endtask : wait_irq

	task automatic new_levels;
		for (int i = 0; i < 100; i += 10)
			levels[i +: 10] <= 10'($random(seed));
		ch = 3'($random(seed));
		@(posedge clk);
	endtask : new_levels

	function automatic logic [31:0] c0(logic [2:0] c, logic [2:0] m, logic t, logic s, logic [1:0] x);
		return {22'h0, x, s, t, m, c};
	endfunction : c0

	// Reference always connected before any start
	function automatic logic [31:0] c1(logic [1:0] dv, logic sh, logic r10, logic [1:0] g);
		return {24'h0, dv, 1'b1, 1'b0, sh, r10, g};
	endfunction : c1

	function automatic logic [31:0] res(int c, logic r10);
		return r10 ? {22'h0, levels[10 * c +: 10]} : {24'h0, levels[10 * c + 2 +: 8]};
	endfunction : res

	function automatic int len(logic sh, logic r10);
		return sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
	endfunction : len

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#400000;
		check("run length", 0, 1);
		close_out();
	end

	initial
	begin
		{psel, penable, pwrite, rst_n} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		trig = 1'b1;
		levels = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1, SAC_IDX_STAT, 32'hffff_ffff);
		for (int i = 0; i < 4; i++)
		begin
			apb(0, i == 0 ? SAC_IDX_CTRL0 : i == 1 ? SAC_IDX_CTRL1 : i == 2 ? SAC_IDX_STAT
				: SAC_IDX_RES0, 0);
			check("reset value", 32'h0, rd);
		end
		apb(1, 10'h3ff, 32'h0000_00aa);
		apb(0, 10'h3ff, 0);
		check("unmapped error", 1, rd_err);
		check("unmapped data", 0, rd);
		// One-shot over resolutions, hold and division
		for (int i = 0; i < 6; i++)
		begin
			d = i < 4 ? 1 : 2 * (i - 3);
			new_levels();
			apb(1, SAC_IDX_CTRL1, c1(i < 4 ? 2'h0 : 2'(i - 3), i < 4 && i[0], i < 4 && i[1], 0));
			irq_n = 0;
			apb(1, SAC_IDX_CTRL0, c0(ch, SAC_MODE_ONESHOT, 0, 1, 0));
			wait_irq(2000);
			n = len(i < 4 && i[0], i < 4 && i[1]) * d;
			check("cycles", 1, cyc >= n && cyc <= n + d + 5);
			apb(0, SAC_IDX_RES0 + ch, 0);
			check("result", res(ch, i < 4 && i[1]), rd);
			apb(0, SAC_IDX_CTRL0, 0);
			check("start cleared", 0, rd[7]);
			check("request count", 1, irq_n);
		end
		for (int x = 1; x < 4; x += 2)
		begin
			apb(1, SAC_IDX_CTRL0, c0(0, SAC_MODE_ONESHOT, 0, 1, 2'(x)));
			wait_irq(2000);
			apb(0, SAC_IDX_RES0 + 10'(8 + x / 2), 0);
			check("extension result", res(8 + x / 2, 0), rd);
		end
		for (int g = 0; g < 4; g++)
		begin
			new_levels();
			apb(1, SAC_IDX_CTRL1, c1(0, 1, 1, 2'(g)));
			irq_n = 0;
			apb(1, SAC_IDX_CTRL0, c0(0, SAC_MODE_SWEEP, 0, 1, 0));
			wait_irq(2000);
			repeat (3) @(posedge clk);
			check("sweep requests", 1, irq_n);
			for (int k = 0; k <= 2 * g + 1; k++)
			begin
				apb(0, SAC_IDX_RES0 + 10'(k), 0);
				check("sweep result", res(k, 1), rd);
			end
		end
		for (int m = 1; m < 5; m += (m == 1) ? 2 : 1)
		begin
			md = 3'(m);
			new_levels();
			apb(1, SAC_IDX_CTRL1, c1(0, 1, 0, 1));
			irq_n = 0;
			apb(1, SAC_IDX_CTRL0, c0(ch, md, 0, 1, 0));
			repeat (600) @(posedge clk);
			apb(0, SAC_IDX_STAT, 0);
			check("still busy", 1, rd[4]);
			apb(1, SAC_IDX_CTRL0, c0(ch, md, 0, 0, 0));
			repeat (4) @(posedge clk);
			apb(0, SAC_IDX_STAT, 0);
			check("stopped", 0, rd[4]);
			check("no requests", 0, irq_n);
			for (int k = 0; k < 4; k++)
			begin
				apb(0, SAC_IDX_RES0 + 10'(m == 1 ? ch : k), 0);
				check("repeat result", res(m == 1 ? ch : k, 0), rd);
			end
		end
		// External trigger, then a retrigger in mid-conversion
		new_levels();
		apb(1, SAC_IDX_CTRL1, c1(0, 0, 1, 0));
		irq_n = 0;
		apb(1, SAC_IDX_CTRL0, c0(ch, SAC_MODE_ONESHOT, 1, 1, 0));
		repeat (100) @(posedge clk);
		check("no start before edge", 0, irq_n);
		trig <= 1'b0;
		wait_irq(500);
		check("trigger cycles", 1, cyc >= 59 && cyc <= 67);
		apb(0, SAC_IDX_CTRL0, 0);
		check("start kept", 1, rd[7]);
		trig <= 1'b1;
		repeat (4) @(posedge clk);
		trig <= 1'b0;
		repeat (30) @(posedge clk);
		trig <= 1'b1;
		repeat (4) @(posedge clk);
		irq_n = 0;
		trig <= 1'b0;
		wait_irq(500);
		check("retrigger cycles", 1, cyc >= 59 && cyc <= 67);
		repeat (3) @(posedge clk);
		check("retrigger requests", 1, irq_n);
		apb(1, SAC_IDX_CTRL0, 0);
		apb(1, SAC_IDX_CTRL1, 32'h0000_00ff);
		apb(0, SAC_IDX_CTRL1, 0);
		// Reserved bit 4 reads back as zero
		check("control 1", 32'h0000_00ef, rd);
		check("ladder on", 1, afe.ref_connect);
		apb(1, SAC_IDX_CTRL1, 0);
		apb(0, SAC_IDX_STAT, 0);
		check("ladder off", 0, afe.ref_connect);
		close_out();
	end
endmodule : sac_top_tb
